// *** src/tocpa_pkg.sv ***
// package: register map, field positions, reset values and counts
package tocpa_pkg;
  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CMP1     = 8'h00;
  localparam logic [7:0] ADDR_CMP2     = 8'h04;
  localparam logic [7:0] ADDR_CMP3     = 8'h08;
  localparam logic [7:0] ADDR_CMP4     = 8'h0C;
  localparam logic [7:0] ADDR_SHARED   = 8'h10;
  localparam logic [7:0] ADDR_FLAGS    = 8'h14;
  localparam logic [7:0] ADDR_IRQEN    = 8'h18;
  localparam logic [7:0] ADDR_ACTION   = 8'h1C;
  localparam logic [7:0] ADDR_FORCE    = 8'h20;
  localparam logic [7:0] ADDR_MASK1    = 8'h24;
  localparam logic [7:0] ADDR_DATA1    = 8'h28;
  localparam logic [7:0] ADDR_DIR      = 8'h2C;
  localparam logic [7:0] ADDR_ACCCTL   = 8'h30;
  localparam logic [7:0] ADDR_ACCCNT   = 8'h34;
  localparam logic [7:0] ADDR_ACCFLAG  = 8'h38;
  localparam logic [7:0] ADDR_COUNTER  = 8'h3C;
  localparam logic [7:0] ADDR_PORTA    = 8'h40;
  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          FLG_CH1_POS   = 7; // ch1..ch4 at bits 7..4
  localparam int          FLG_SHARED    = 3; // shared ch5 flag bit
  localparam int          FORCE_CH1_POS = 7; // force ch1..ch5 at 7..3
  localparam int          ACC_EDGE_POS  = 4;
  localparam int          ACC_MODE_POS  = 5;
  localparam int          ACC_EN_POS    = 6;
  localparam int          SHARED_SEL_POS = 2;
  localparam int          ACC_OVF_POS   = 5;
  localparam int          BIT3_DIR_POS  = 3;
  localparam logic [15:0] CMP_RESET     = 16'hFFFF;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int          GATED_DIV     = 64;
  localparam logic [5:0]  GATED_LAST    = 6'(GATED_DIV - 1);
endpackage

// *** src/tocpa_pin_action.sv ***
// pin action decoder for one single-pin compare channel
module tocpa_pin_action
  import tocpa_pkg::*;
(
  input  wire logic [1:0] i_mode_level,
  input  wire logic       i_fire,
  input  wire logic       i_pin,
  output logic            o_hit,
  output logic            o_val
);
  // ----------------------------------------------------------------------
  // decode mode/level pair
  // ----------------------------------------------------------------------
  // 00 none, 01 toggle, 10 low, 11 high
  always_comb begin
    o_hit = i_fire && (i_mode_level != 2'h0);
    unique case (i_mode_level)
      2'h1:    o_val = ~i_pin;
      2'h2:    o_val = 1'b0;
      2'h3:    o_val = 1'b1;
      2'h0:    o_val = i_pin;
    endcase
  end
endmodule

// *** src/tocpa_accum.sv ***
// pulse accumulator: edge counter and gated divide-by-64 counter
module tocpa_accum
  import tocpa_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_enable,
  input  wire logic       i_mode,
  input  wire logic       i_edge,
  input  wire logic       i_pin,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wdata,
  output logic [7:0]      o_count,
  output logic            o_wrap,
  output logic            o_edge_seen
);
  logic       pin_q;
  logic [5:0] div_q;
  logic       step;
  logic       edge_hit;

  // ----------------------------------------------------------------------
  // edge detection and prescaler
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) pin_q <= 1'b0;
    else          pin_q <= i_pin;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n)                  div_q <= 6'h00;
    else if (div_q == GATED_LAST)  div_q <= 6'h00;
    else                           div_q <= div_q + 6'h01;
  end

  // edge 0 falling, 1 rising; gated mode stops when pin equals edge bit
  always_comb begin
    edge_hit = i_edge ? (i_pin && !pin_q) : (!i_pin && pin_q);
    if (!i_enable)   step = 1'b0;
    else if (i_mode) step = (div_q == GATED_LAST) && (i_pin != i_edge);
    else             step = edge_hit;
  end

  assign o_edge_seen = i_enable && !i_mode && edge_hit;
  assign o_wrap      = step && !i_wr && (o_count == 8'hFF);

  // ----------------------------------------------------------------------
  // count register, writable at any time
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n)   o_count <= BYTE_RESET;
    else if (i_wr)  o_count <= i_wdata;
    else if (step)  o_count <= o_count + 8'h01;
  end
endmodule

// *** src/tocpa_top.sv ***
// output compare channels and pulse accumulator behind an ahb-lite slave
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
module tocpa_top
  import tocpa_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  input  wire logic [7:0]  i_port_a_in,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [7:0]       o_port_a_out,
  output logic [7:0]       o_port_a_oe,
  output logic             o_irq
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  // index 0..3 channels 1..4, index 4 shared
  logic [15:0] compare_value_q [5];
  logic [15:0] counter_q;
  logic [7:0]  timer_event_flags_q;
  logic [7:0]  timer_event_irq_enables_q;
  logic [7:0]  compare_pin_action_control_q;
  logic [4:0]  force_pending_q;
  logic [7:0]  chan1_pin_select_mask_q;
  logic [7:0]  chan1_pin_drive_data_q;
  logic [7:0]  port_a_direction_q;
  logic [7:0]  acc_ctl_q;
  logic        acc_ovf_q;
  logic [7:0]  port_latch_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] rdata_d;
  logic        addr_ok;
  logic        wr_now;
  logic [4:0]  match;
  logic [4:0]  fire;
  logic [7:0]  port_d;
  logic [7:0]  port_base;
  logic [7:0]  set_flags;
  logic        comp5_sel;
  logic [7:0]  acc_count;
  logic        acc_wrap;
  logic [3:0]  ch_hit;
  logic [3:0]  ch_val;

  // ----------------------------------------------------------------------
  // bus address phase: capture writes, always ready, always okay
  // ----------------------------------------------------------------------
  // only whole-word nonseq transfers count;
  // idle cycles and other sizes are ignored
  assign addr_ok = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ)
                   && (i_hsize == HSIZE_WORD);

  // write data follows one cycle later,
  // so address and intent are held here
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && i_hwrite;
      if (addr_ok) wr_addr_q <= i_haddr[7:0];
    end
  end

  assign wr_now = wr_pend_q;

  // zero wait states, never an error
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // free-running counter
  // ----------------------------------------------------------------------
  // one count per bus clock, wraps at all ones
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) counter_q <= 16'h0000;
    else          counter_q <= counter_q + 16'h0001;
  end

  // ----------------------------------------------------------------------
  // compare registers and comparators
  // ----------------------------------------------------------------------
  // one comparator and storage word per channel;
  // flags are not consulted, so a stale flag
  // never blocks a later pin action
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_cmp
      always_ff @(posedge i_clk) begin
        if (!i_rst_n)
          compare_value_q[g] <= CMP_RESET;
        else if (wr_now && wr_addr_q == ADDR_CMP1 + 8'(4 * g))
          compare_value_q[g] <= i_hwdata[15:0];
      end
      // every cycle compare against counter
      assign match[g] = (compare_value_q[g] == counter_q);
      // force turns into action on the next counter transition
      assign fire[g]  = match[g] || force_pending_q[g];
    end
  endgenerate

  // compare 5 only active with bit3 output and select clear
  // with select set, the shared word is storage
  assign comp5_sel = port_a_direction_q[BIT3_DIR_POS]
                     && !acc_ctl_q[SHARED_SEL_POS];

  // ----------------------------------------------------------------------
  // force strobes: written ones held one cycle, then act
  // ----------------------------------------------------------------------
  // a pending force lives one cycle only
  // and a zero bit leaves its channel alone;
  // force next to a real match may toggle twice
  always_ff @(posedge i_clk) begin
    if (!i_rst_n)
      force_pending_q <= 5'h00;
    else if (wr_now && wr_addr_q == ADDR_FORCE)
      force_pending_q <= {i_hwdata[FORCE_CH1_POS - 4],
                          i_hwdata[FORCE_CH1_POS - 3],
                          i_hwdata[FORCE_CH1_POS - 2],
                          i_hwdata[FORCE_CH1_POS - 1],
                          i_hwdata[FORCE_CH1_POS]};
    else
      force_pending_q <= 5'h00;
  end

  // ----------------------------------------------------------------------
  // event flags: set wins over write-one-clear
  // ----------------------------------------------------------------------
  // bits 2..0 have no source and read zero
  always_comb begin
    set_flags = 8'h00;
    for (int i = 0; i < 4; i++)
      set_flags[FLG_CH1_POS - i] = match[i];
    set_flags[FLG_SHARED] = match[4] && comp5_sel;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n)
      timer_event_flags_q <= BYTE_RESET;
    else if (wr_now && wr_addr_q == ADDR_FLAGS)
      timer_event_flags_q <= (timer_event_flags_q & ~i_hwdata[7:0])
                             | set_flags;
    else
      timer_event_flags_q <= timer_event_flags_q | set_flags;
  end

  // ----------------------------------------------------------------------
  // plain control registers
  // ----------------------------------------------------------------------
  // mask and data keep bits 7..3 only;
  // the accumulator control byte also holds
  // the compare/storage select of the shared channel
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      timer_event_irq_enables_q    <= BYTE_RESET;
      compare_pin_action_control_q <= BYTE_RESET;
      chan1_pin_select_mask_q      <= BYTE_RESET;
      chan1_pin_drive_data_q       <= BYTE_RESET;
      port_a_direction_q           <= BYTE_RESET;
      acc_ctl_q                    <= BYTE_RESET;
    end else if (wr_now) begin
      unique case (wr_addr_q)
        ADDR_IRQEN:  timer_event_irq_enables_q    <= i_hwdata[7:0];
        ADDR_ACTION: compare_pin_action_control_q <= i_hwdata[7:0];
        ADDR_MASK1:  chan1_pin_select_mask_q <= {i_hwdata[7:3], 3'h0};
        ADDR_DATA1:  chan1_pin_drive_data_q  <= {i_hwdata[7:3], 3'h0};
        ADDR_DIR:    port_a_direction_q           <= i_hwdata[7:0];
        ADDR_ACCCTL: acc_ctl_q                    <= i_hwdata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // interrupt output from enabled flags
  // ----------------------------------------------------------------------
  // level request: drops one cycle after
  // the flag or the enable is cleared;
  // compare 5 counts only while selected
  always_ff @(posedge i_clk) begin
    if (!i_rst_n)
      o_irq <= 1'b0;
    else
      o_irq <= |(timer_event_flags_q[7:4] & timer_event_irq_enables_q[7:4])
               || (comp5_sel && timer_event_flags_q[FLG_SHARED]
                   && timer_event_irq_enables_q[FLG_SHARED]);
  end

  // ----------------------------------------------------------------------
  // pin actions for channels 2..5, then channel 1 mask
  // ----------------------------------------------------------------------
  // one decoder per pin, bit 6 down to bit 3
  generate
    for (g = 0; g < 4; g++) begin : g_pin
      tocpa_pin_action u_act (
        .i_mode_level (compare_pin_action_control_q[7 - 2*g -: 2]),
        .i_fire       (fire[g + 1]),
        .i_pin        (port_base[6 - g]),
        .o_hit        (ch_hit[g]),
        .o_val        (ch_val[g])
      );
    end
  endgenerate

  // a port write and a compare action in one cycle both take effect:
  // the action is applied on top of the written value, so no match
  // is lost to a colliding write
  assign port_base = (wr_now && wr_addr_q == ADDR_PORTA) ? i_hwdata[7:0]
                                                           : port_latch_q;

  // channel 1 last, so it wins a shared pin
  always_comb begin
    port_d = port_base;
    for (int i = 0; i < 3; i++)
      if (ch_hit[i]) port_d[6 - i] = ch_val[i];
    if (ch_hit[3] && comp5_sel) port_d[3] = ch_val[3];
    // channel 1 overrides in its masked bits
    if (fire[0])
      port_d[7:3] = (port_d[7:3] & ~chan1_pin_select_mask_q[7:3])
                  | (chan1_pin_drive_data_q[7:3]
                     & chan1_pin_select_mask_q[7:3]);
  end

  // the latch holds the pins between actions
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) port_latch_q <= BYTE_RESET;
    else          port_latch_q <= port_d;
  end

  // outputs lag the latch by one cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_port_a_out <= BYTE_RESET;
      o_port_a_oe  <= BYTE_RESET;
    end else begin
      o_port_a_out <= port_latch_q;
      o_port_a_oe  <= port_a_direction_q;
    end
  end

  // ----------------------------------------------------------------------
  // pulse accumulator fed by the pad level of bit 7
  // ----------------------------------------------------------------------
  // fed from the pad, not the latch, so an
  // output pin still drives the count
  tocpa_accum u_acc (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_enable    (acc_ctl_q[ACC_EN_POS]),
    .i_mode      (acc_ctl_q[ACC_MODE_POS]),
    .i_edge      (acc_ctl_q[ACC_EDGE_POS]),
    .i_pin       (i_port_a_in[7]),
    .i_wr        (wr_now && wr_addr_q == ADDR_ACCCNT),
    .i_wdata     (i_hwdata[7:0]),
    .o_count     (acc_count),
    .o_wrap      (acc_wrap),
    .o_edge_seen ()
  );

  // set wins over a clearing write
  always_ff @(posedge i_clk) begin
    if (!i_rst_n)
      acc_ovf_q <= 1'b0;
    else if (acc_wrap)
      acc_ovf_q <= 1'b1;
    else if (wr_now && wr_addr_q == ADDR_ACCFLAG && i_hwdata[ACC_OVF_POS])
      acc_ovf_q <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // read data, registered in the data phase
  // ----------------------------------------------------------------------
  // chosen in the address phase and held
  // until the next read is accepted
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (i_haddr[7:0])
      ADDR_CMP1:    rdata_d[15:0] = compare_value_q[0];
      ADDR_CMP2:    rdata_d[15:0] = compare_value_q[1];
      ADDR_CMP3:    rdata_d[15:0] = compare_value_q[2];
      ADDR_CMP4:    rdata_d[15:0] = compare_value_q[3];
      ADDR_SHARED:  rdata_d[15:0] = compare_value_q[4];
      ADDR_FLAGS:   rdata_d[7:0]  = timer_event_flags_q;
      ADDR_IRQEN:   rdata_d[7:0]  = timer_event_irq_enables_q;
      ADDR_ACTION:  rdata_d[7:0]  = compare_pin_action_control_q;
      ADDR_MASK1:   rdata_d[7:0]  = chan1_pin_select_mask_q;
      ADDR_DATA1:   rdata_d[7:0]  = chan1_pin_drive_data_q;
      ADDR_DIR:     rdata_d[7:0]  = port_a_direction_q;
      ADDR_ACCCTL:  rdata_d[7:0]  = acc_ctl_q;
      ADDR_ACCCNT:  rdata_d[7:0]  = acc_count;
      ADDR_ACCFLAG: rdata_d[ACC_OVF_POS] = acc_ovf_q;
      ADDR_COUNTER: rdata_d[15:0] = counter_q;
      ADDR_PORTA:   rdata_d[7:0]  = i_port_a_in;
      default:      rdata_d = 32'h0000_0000;
    endcase
  end

  // writes leave the read data untouched
  always_ff @(posedge i_clk) begin
    if (!i_rst_n)                      o_hrdata <= 32'h0000_0000;
    else if (addr_ok && !i_hwrite)     o_hrdata <= rdata_d;
  end
endmodule

// *** tb/tocpa_properties.sv ***
// checker: port-level properties of the compare and accumulator block
module tocpa_prop_chk
  import tocpa_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [2:0]  i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic        i_hready,
  input wire logic [7:0]  i_port_a_in,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [7:0]  o_port_a_out,
  input wire logic [7:0]  o_port_a_oe,
  input wire logic        o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       take;
  logic       rd_take;
  logic [7:0] ra;
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [7:0] dir_q;
  logic [4:0] irqen_q;
  // address phase accepted by the slave
  assign take    = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ
                   && i_hsize == HSIZE_WORD;
  assign rd_take = take && !i_hwrite;
  assign ra      = i_haddr[7:0];
  // pending write and mirrors of the direction and enable registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      dir_q     <= 8'h00;
      irqen_q   <= 5'h00;
    end else begin
      wr_pend_q <= take && i_hwrite;
      wr_addr_q <= ra;
      if (wr_pend_q && wr_addr_q == ADDR_DIR) begin
        dir_q <= i_hwdata[7:0];
      end
      if (wr_pend_q && wr_addr_q == ADDR_IRQEN) begin
        irqen_q <= i_hwdata[7:3];
      end
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  property p_ready; o_hreadyout && !o_hresp; endproperty
  a_ready: assert property (p_ready) else $error("bus stalled or errored");
  property p_stands; $changed(o_hrdata) |-> $past(rd_take); endproperty
  a_stands: assert property (p_stands) else $error("read data moved");
  property p_zero;
    rd_take && (ra == 8'h44 || ra == ADDR_FORCE) |=> o_hrdata == 32'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("empty read not zero");
  property p_wide;
    rd_take && ra <= ADDR_SHARED |=> o_hrdata[31:16] == 16'h0;
  endproperty
  a_wide: assert property (p_wide) else $error("compare read too wide");
  property p_narrow;
    rd_take && ra > ADDR_SHARED && ra != ADDR_COUNTER
      |=> o_hrdata[31:8] == 24'h0;
  endproperty
  a_narrow: assert property (p_narrow) else $error("byte read too wide");
  property p_oe; o_port_a_oe == $past(dir_q); endproperty
  a_oe: assert property (p_oe) else $error("enable differs from dir");
  property p_dir_rd;
    rd_take && ra == ADDR_DIR |=> o_hrdata[7:0] == $past(dir_q);
  endproperty
  a_dir_rd: assert property (p_dir_rd) else $error("dir readback");
  property p_irq_off; (irqen_q == 5'h00) [*2] |=> !o_irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("masked irq");
  property p_en_rd;
    rd_take && ra == ADDR_IRQEN |=> o_hrdata[7:3] == $past(irqen_q);
  endproperty
  a_en_rd: assert property (p_en_rd) else $error("enable readback");
endmodule

bind tocpa_top tocpa_prop_chk u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
  .i_hwdata(i_hwdata), .i_hready(i_hready), .i_port_a_in(i_port_a_in),
  .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_port_a_out(o_port_a_out), .o_port_a_oe(o_port_a_oe), .o_irq(o_irq)
);

// *** tb/tocpa_pins_model.sv ***
// partner model of the port A pads with a pulse source on bit 7
module tocpa_pins_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  output logic [7:0]      o_pads
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ext_q = 8'h00;
  // a driven pin shows its own level, to the accumulator as well
  assign o_pads = (i_oe & i_out) | (~i_oe & ext_q);
  // outside level of one pin, changed just after an edge
  task automatic set_lvl(input int b, input logic v);
    @(posedge i_clk);
    ext_q[b] <= v;
  endtask
  // pulses two cycles high, four low between pulses: well under half the clock rate
  task automatic make_edges(input int n);
    repeat (n) begin
      @(posedge i_clk);
      ext_q[7] <= 1'b1;
      repeat (2) @(posedge i_clk);
      ext_q[7] <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
  endtask
endmodule

// *** tb/tocpa_tb.sv ***
// self-checking bench of the compare channels and pulse accumulator
module testbench
  import tocpa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk    = 1'b0;
  logic        rst_n  = 1'b0;
  logic        hsel   = 1'b0;
  logic [31:0] haddr  = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [7:0]  pa_out;
  logic [7:0]  pa_oe;
  logic [7:0]  pads;
  logic        irq;
  logic [31:0] r;
  int          error_cnt = 0;
  int          n_checks  = 0;
  // 25 MHz bus clock
  always #20 clk = ~clk;
  tocpa_top u_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(HSIZE_WORD),
    .i_hwdata(hwdata), .i_hready(hready), .i_port_a_in(pads),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .o_port_a_out(pa_out), .o_port_a_oe(pa_oe), .o_irq(irq)
  );
  tocpa_pins_model u_pins (
    .i_clk(clk), .i_out(pa_out), .i_oe(pa_oe), .o_pads(pads)
  );
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // waits until hready is sampled high at a rising edge
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge clk);
    while (hready !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    if (k == 50) begin
      error_cnt++;
      $display("ERROR %0t: no hready", $time);
    end
  endtask
  // one single word transfer; read data lands in r
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {24'h0, a};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  // arms a compare 40 counts ahead of the free-running counter
  task automatic match(input logic [7:0] a);
    bus(1'b0, ADDR_COUNTER, 32'h0);
    wr(a, {16'h0, r[15:0] + 16'h0028});
    cyc(60);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      rdchk(ADDR_CMP1 + 8'(4 * i), 32'h0000FFFF);
    end
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_CMP1 + 8'(4 * i), 32'hABCD5A50 + 32'(i));
      rdchk(ADDR_CMP1 + 8'(4 * i), 32'h00005A50 + 32'(i));
      wr(ADDR_CMP1 + 8'(4 * i), 32'h0000FFFF);
    end
    wr(8'h44, 32'h000000FF);
    rdchk(8'h44, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_modes();
    logic [1:0]  m;
    logic [31:0] e;
    wr(ADDR_IRQEN, 32'h000000F8);
    wr(ADDR_DIR, 32'h000000FF);
    wr(ADDR_PORTA, 32'h0);
    chk({24'h0, pa_oe}, 32'h000000FF);
    for (int c = 2; c < 6; c++) begin
      for (int k = 0; k < 3; k++) begin
        m = (k == 0) ? 2'h3 : {k == 2, 1'b0};
        e = (k < 2) ? 32'h1 << (8 - c) : 32'h0;
        wr(ADDR_ACTION, 32'(m) << (2 * (5 - c)));
        wr(ADDR_FORCE, 32'h1 << (8 - c));
        cyc(3);
        chk({24'h0, pa_out}, e);
      end
    end
    rdchk(ADDR_FLAGS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test modes done");
  endtask
  task automatic t_toggle();
    wr(ADDR_ACTION, 32'h00000040);
    match(ADDR_CMP2);
    chk({24'h0, pa_out}, 32'h00000040);
    chk({31'h0, irq}, 32'h1);
    match(ADDR_CMP2);
    chk({24'h0, pa_out}, 32'h0);
    wr(ADDR_IRQEN, 32'h0);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_IRQEN, 32'h000000F8);
    wr(ADDR_FLAGS, 32'h0);
    rdchk(ADDR_FLAGS, 32'h00000040);
    wr(ADDR_FLAGS, 32'h00000040);
    rdchk(ADDR_FLAGS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test toggle done");
  endtask
  task automatic t_chan1();
    wr(ADDR_PORTA, 32'h00000070);
    wr(ADDR_ACTION, 32'h0);
    wr(ADDR_MASK1, 32'h000000AF);
    wr(ADDR_DATA1, 32'h0000008F);
    wr(ADDR_FORCE, 32'h00000080);
    cyc(3);
    chk({24'h0, pa_out}, 32'h000000D8);
    wr(ADDR_DATA1, 32'h0);
    match(ADDR_CMP1);
    chk({24'h0, pa_out}, 32'h00000050);
    rdchk(ADDR_FLAGS, 32'h00000080);
    wr(ADDR_FLAGS, 32'h000000F8);
    wr(ADDR_MASK1, 32'h0);
    $display("test chan1 done");
  endtask
  task automatic t_shared();
    wr(ADDR_PORTA, 32'h0);
    wr(ADDR_ACTION, 32'h00000003);
    wr(ADDR_ACCCTL, 32'h00000004);
    match(ADDR_SHARED);
    rdchk(ADDR_FLAGS, 32'h0);
    chk({24'h0, pa_out}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_ACCCTL, 32'h0);
    match(ADDR_SHARED);
    rdchk(ADDR_FLAGS, 32'h00000008);
    chk({24'h0, pa_out}, 32'h00000008);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_FLAGS, 32'h00000008);
    $display("test shared done");
  endtask
  task automatic t_accum();
    logic [31:0] c;
    wr(ADDR_DIR, 32'h0);
    wr(ADDR_ACCCTL, 32'h00000050);
    wr(ADDR_ACCCNT, 32'h000000FE);
    u_pins.make_edges(3);
    rdchk(ADDR_ACCCNT, 32'h00000001);
    rdchk(ADDR_ACCFLAG, 32'h00000020);
    wr(ADDR_ACCFLAG, 32'h00000020);
    wr(ADDR_ACCCTL, 32'h00000040);
    wr(ADDR_ACCCNT, 32'h0);
    u_pins.make_edges(2);
    rdchk(ADDR_ACCCNT, 32'h00000002);
    wr(ADDR_DIR, 32'h00000080);
    for (int j = 0; j < 4; j++) begin
      wr(ADDR_PORTA, (j % 2 == 0) ? 32'h00000080 : 32'h0);
    end
    cyc(3);
    rdchk(ADDR_ACCCNT, 32'h00000004);
    wr(ADDR_DIR, 32'h0);
    for (int m = 0; m < 2; m++) begin
      u_pins.set_lvl(7, m == 0);
      wr(ADDR_ACCCTL, 32'h00000060 | (32'(m) << 4));
      wr(ADDR_ACCCNT, 32'h0);
      cyc(320);
      bus(1'b0, ADDR_ACCCNT, 32'h0);
      chk({31'h0, r >= 4 && r <= 6}, 32'h1);
      u_pins.set_lvl(7, m == 1);
      cyc(4);
      bus(1'b0, ADDR_ACCCNT, 32'h0);
      c = r;
      cyc(200);
      rdchk(ADDR_ACCCNT, c);
    end
    $display("test accum done");
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // main sequence after five cycles of reset
  initial begin
    cyc(5);
    rst_n <= 1'b1;
    cyc(1);
    t_regs();
    t_modes();
    t_toggle();
    t_chan1();
    t_shared();
    t_accum();
    give_verdict();
  end
  // watchdog well beyond the expected run of under two thousand cycles
  initial begin
    cyc(20000);
    error_cnt++;
    $display("ERROR %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule
